// ===== rtl/eem_pkg.sv
/*
 Constants, variant codes and protocol states of the two-wire EEPROM slave.
 Assumes a 100 MHz system clock; the bus clock comes from the master.
*/
package eem_pkg;

    typedef enum logic [1:0] {
        EEM_1K = 2'h0,
        EEM_2K = 2'h1,
        EEM_4K = 2'h2
    } eem_variant_t;

    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_DEV = 8'h02,
        ST_WADDR = 8'h04,
        ST_WDATA = 8'h08,
        ST_ACK = 8'h10,
        ST_RLOAD = 8'h20,
        ST_RDATA = 8'h40,
        ST_RACK = 8'h80
    } eem_state_t;

    localparam int ADDR_W = 9;
    localparam int MEM_DEPTH = 512;
    localparam int DATA_W = 8;
    localparam int BUF_DEPTH = 16;
    localparam logic [8:0] MASK_1K = 9'h07F;
    localparam logic [8:0] MASK_2K = 9'h0FF;
    localparam logic [8:0] MASK_4K = 9'h1FF;
    localparam logic [3:0] PAGE_MASK_SMALL = 4'h3;
    localparam logic [3:0] PAGE_MASK_4K = 4'hF;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BUF_LAST = 4'hF;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam int BANK_BIT = 1;
    localparam int RW_BIT = 0;

    localparam int CLK_MHZ = 100;
    localparam int WR_TIME_HI_MS = 10;
    localparam int WR_TIME_LO_MS = 25;
    localparam int WR_CYCLES_HI = WR_TIME_HI_MS * 1000 * CLK_MHZ;
    localparam int WR_CYCLES_LO = WR_TIME_LO_MS * 1000 * CLK_MHZ;

endpackage

// ===== rtl/eem_mem_if.sv
/*
 Port between the protocol engine and the storage array.
 Assumes both ends run on the system clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface eem_mem_if;
    import eem_pkg::*;
    logic wr_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    modport ctrl (output wr_en, output addr, output wdata, input rdata);
    modport mem (input wr_en, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ===== rtl/eem_mem.sv
/*
 Byte array with registered read data and one write port.
 Assumes address, write data and enable come from registers.
*/
`timescale 1ns/100ps
`default_nettype none
module eem_mem (
    input wire logic clk,
    input wire logic rst,
    eem_mem_if.mem bus
);
    import eem_pkg::*;

    typedef struct packed {
        logic [MEM_DEPTH-1:0][DATA_W-1:0] cells;
        logic [DATA_W-1:0] rdata;
    } eem_mem_state_t;

    eem_mem_state_t st_reg;
    eem_mem_state_t st_next;

    always_comb begin
        st_next = st_reg;
        st_next.rdata = st_reg.cells[bus.addr];
        if (bus.wr_en) begin
            st_next.cells[bus.addr] = bus.wdata;
        end
    end

    // Erased state after reset
    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg <= {MEM_DEPTH+1{ERASED_BYTE}};
        end else begin
            st_reg <= st_next;
        end
    end

    assign bus.rdata = st_reg.rdata;

endmodule // eem_mem
`default_nettype wire

// ===== rtl/eem_slave.sv
/*
 Two-wire bus slave of a small serial EEPROM: start and stop detection,
 slave address decode, acknowledge, byte and page write committed on stop,
 current, random and sequential read.
 Assumes scl_clk is the bus clock pin, sda an open-drain line resolved
 outside, straps static pins, clk at 100 MHz unrelated to scl_clk.
*/
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - Start is SDA falling while SCL high
// - Commands run only after recognised start
// - Stop is SDA rising while SCL high
// - Write data committed only at stop
// - Upper four address bits match type code
// - Small variants match three strap pins
// - Lowest address bit: 0 write, 1 read
// - Large variant matches two strap pins
// - Bank bit selects upper or lower half
// - Receiver pulls SDA low on ninth clock
// - Transmitter releases SDA after eight bits
// - Master ack low: send next address byte
// - No ack: release, end at stop
// - Byte write stores at sent address
// - 1K page: low two bits increment
// - 2K page: low two bits increment
// - 4K page: low four bits increment
// - Current read returns last address plus one
// - Random read uses loaded word address
// - Sample on SCL rise, change after fall
// - Internal write cycle follows committing stop
module eem_slave #(
    parameter eem_pkg::eem_variant_t VARIANT = eem_pkg::EEM_4K,
    // Device type code, value arbitrary
    parameter logic [3:0] DEV_TYPE = 4'h5,
    parameter int WRITE_CYCLES = eem_pkg::WR_CYCLES_HI
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl_clk,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic strap_addr_bit0,
    input wire logic strap_addr_bit1,
    input wire logic strap_addr_bit2,
    output logic write_busy
);
    import eem_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Link side: bit capture on the bus clock

    typedef struct packed {
        logic bit_val;
        logic tog;
    } eem_link_t;

    eem_link_t lk_reg;
    eem_link_t lk_next;

    always_comb begin
        lk_next = lk_reg;
        lk_next.bit_val = sda_in;
        lk_next.tog = ~lk_reg.tog;
    end

    always_ff @(posedge scl_clk) begin
        if (rst) begin
            lk_reg <= '0;
        end else begin
            lk_reg <= lk_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic dev_match(input logic [7:0] b,
                                       input logic [2:0] straps);
        logic hit;
        hit = (b[7:4] == DEV_TYPE);
        if (VARIANT == EEM_4K) begin
            hit = hit && (b[3:2] == straps[2:1]);
        end else begin
            hit = hit && (b[3:1] == straps);
        end
        return hit;
    endfunction

    function automatic logic [8:0] arr_mask();
        logic [8:0] m;
        case (VARIANT)
            EEM_1K: m = MASK_1K;
            EEM_2K: m = MASK_2K;
            default: m = MASK_4K;
        endcase
        return m;
    endfunction

    function automatic logic [3:0] page_mask();
        logic [3:0] m;
        if (VARIANT == EEM_4K) begin
            m = PAGE_MASK_4K;
        end else begin
            m = PAGE_MASK_SMALL;
        end
        return m;
    endfunction

    // Sequential read step, wraps at array end
    function automatic logic [8:0] arr_inc(input logic [8:0] a);
        return (a + 9'h001) & arr_mask();
    endfunction

    // Page write step, wraps inside the page
    function automatic logic [8:0] page_inc(input logic [8:0] a);
        logic [8:0] pm;
        pm = {5'h00, page_mask()};
        return (a & ~pm) | ((a + 9'h001) & pm);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // System side state

    typedef struct packed {
        logic scl_m;
        logic scl_s;
        logic scl_d;
        logic sda_m;
        logic sda_s;
        logic sda_d;
        logic tog_m;
        logic tog_s;
        logic tog_d;
        logic [2:0] strap_m;
        logic [2:0] strap_s;
        eem_state_t state;
        eem_state_t after_ack;
        logic [3:0] cnt;
        logic [7:0] shreg;
        logic rw;
        logic bank;
        logic [8:0] addr;
        logic [BUF_DEPTH-1:0][7:0] wbuf;
        logic [BUF_DEPTH-1:0] valid;
        logic [8:0] wbase;
        logic commit;
        logic [3:0] cidx;
        logic [31:0] busy_cnt;
        logic mem_we;
        logic [8:0] mem_addr;
        logic [7:0] mem_wd;
        logic sda_out;
        logic sda_oe_n;
        logic busy;
    } eem_state_reg_t;

    eem_state_reg_t st_reg;
    eem_state_reg_t st_next;

    eem_mem_if mif ();

    logic rise_ev;
    logic fall_ev;
    logic start_ev;
    logic stop_ev;
    logic in_bit;
    logic busy_now;
    logic [7:0] rx_byte;

    always_comb begin
        rise_ev = st_reg.tog_s ^ st_reg.tog_d;
        fall_ev = st_reg.scl_d & ~st_reg.scl_s;
        start_ev = st_reg.scl_s & st_reg.scl_d
                   & st_reg.sda_d & ~st_reg.sda_s;
        stop_ev = st_reg.scl_s & st_reg.scl_d
                  & ~st_reg.sda_d & st_reg.sda_s;
        in_bit = lk_reg.bit_val;
        busy_now = st_reg.commit | (st_reg.busy_cnt != 32'h0);
        rx_byte = {st_reg.shreg[6:0], in_bit};
    end

    always_comb begin
        st_next = st_reg;
        st_next.scl_m = scl_clk;
        st_next.scl_s = st_reg.scl_m;
        st_next.scl_d = st_reg.scl_s;
        st_next.sda_m = sda_in;
        st_next.sda_s = st_reg.sda_m;
        st_next.sda_d = st_reg.sda_s;
        st_next.tog_m = lk_reg.tog;
        st_next.tog_s = st_reg.tog_m;
        st_next.tog_d = st_reg.tog_s;
        st_next.strap_m = {strap_addr_bit2, strap_addr_bit1,
                           strap_addr_bit0};
        st_next.strap_s = st_reg.strap_m;
        st_next.sda_out = 1'b0;
        st_next.mem_we = 1'b0;

        // Write commit and internal write cycle
        if (st_reg.commit) begin
            st_next.mem_addr = (st_reg.wbase & ~{5'h00, page_mask()})
                               | {5'h00, st_reg.cidx};
            st_next.mem_wd = st_reg.wbuf[st_reg.cidx];
            st_next.mem_we = st_reg.valid[st_reg.cidx]
                             & ((st_reg.cidx & ~page_mask()) == 4'h0);
            st_next.cidx = st_reg.cidx + 4'h1;
            if (st_reg.cidx == BUF_LAST) begin
                st_next.commit = 1'b0;
                st_next.valid = '0;
                st_next.busy_cnt = 32'(WRITE_CYCLES);
            end
        end else if (st_reg.busy_cnt != 32'h0) begin
            st_next.busy_cnt = st_reg.busy_cnt - 32'h1;
        end

        if (start_ev) begin
            // Unfinished write is dropped
            st_next.state = ST_DEV;
            st_next.cnt = 4'h0;
            st_next.sda_oe_n = 1'b1;
            if (!st_reg.commit) begin
                st_next.valid = '0;
            end
        end else if (stop_ev) begin
            if (st_reg.state == ST_WDATA && st_reg.valid != '0
                && !st_reg.commit) begin
                st_next.commit = 1'b1;
                st_next.cidx = 4'h0;
            end
            st_next.state = ST_IDLE;
            st_next.sda_oe_n = 1'b1;
        end else begin
            case (st_reg.state)
                ST_IDLE: begin
                    st_next.sda_oe_n = 1'b1;
                end
                ST_DEV: begin
                    if (rise_ev) begin
                        st_next.shreg = rx_byte;
                        st_next.cnt = st_reg.cnt + 4'h1;
                        if (st_reg.cnt == BIT_LAST) begin
                            st_next.cnt = 4'h0;
                            if (dev_match(rx_byte, st_reg.strap_s)
                                && !busy_now) begin
                                st_next.rw = rx_byte[RW_BIT];
                                st_next.state = ST_ACK;
                                if (rx_byte[RW_BIT]) begin
                                    st_next.after_ack = ST_RLOAD;
                                end else begin
                                    st_next.after_ack = ST_WADDR;
                                end
                                if (VARIANT == EEM_4K) begin
                                    st_next.bank = rx_byte[BANK_BIT];
                                    st_next.addr[8] =
                                        rx_byte[BANK_BIT];
                                end
                            end else begin
                                st_next.state = ST_IDLE;
                            end
                        end
                    end
                end
                ST_WADDR: begin
                    if (rise_ev) begin
                        st_next.shreg = rx_byte;
                        st_next.cnt = st_reg.cnt + 4'h1;
                        if (st_reg.cnt == BIT_LAST) begin
                            st_next.cnt = 4'h0;
                            st_next.addr = {st_reg.bank, rx_byte}
                                           & arr_mask();
                            st_next.valid = '0;
                            st_next.state = ST_ACK;
                            st_next.after_ack = ST_WDATA;
                        end
                    end
                end
                ST_WDATA: begin
                    if (rise_ev) begin
                        st_next.shreg = rx_byte;
                        st_next.cnt = st_reg.cnt + 4'h1;
                        if (st_reg.cnt == BIT_LAST) begin
                            st_next.cnt = 4'h0;
                            st_next.wbuf[st_reg.addr[3:0] & page_mask()]
                                = rx_byte;
                            st_next.valid[st_reg.addr[3:0]
                                          & page_mask()] = 1'b1;
                            st_next.wbase = st_reg.addr;
                            st_next.addr = page_inc(st_reg.addr);
                            st_next.state = ST_ACK;
                            st_next.after_ack = ST_WDATA;
                        end
                    end
                end
                ST_ACK: begin
                    // First fall drives the ack, second ends it
                    if (fall_ev) begin
                        if (st_reg.cnt == 4'h0) begin
                            st_next.sda_oe_n = 1'b0;
                            st_next.cnt = 4'h1;
                        end else begin
                            st_next.cnt = 4'h0;
                            st_next.sda_oe_n = 1'b1;
                            st_next.state = st_reg.after_ack;
                            if (st_reg.after_ack == ST_RLOAD) begin
                                st_next.shreg = mif.rdata;
                                st_next.sda_oe_n = mif.rdata[7];
                                st_next.state = ST_RDATA;
                            end
                        end
                    end
                end
                ST_RLOAD: begin
                    if (fall_ev) begin
                        st_next.shreg = mif.rdata;
                        st_next.sda_oe_n = mif.rdata[7];
                        st_next.cnt = 4'h0;
                        st_next.state = ST_RDATA;
                    end
                end
                ST_RDATA: begin
                    if (fall_ev) begin
                        if (st_reg.cnt == BIT_LAST) begin
                            st_next.sda_oe_n = 1'b1;
                            st_next.addr = arr_inc(st_reg.addr);
                            st_next.cnt = 4'h0;
                            st_next.state = ST_RACK;
                        end else begin
                            st_next.shreg = {st_reg.shreg[6:0], 1'b0};
                            st_next.sda_oe_n = st_reg.shreg[6];
                            st_next.cnt = st_reg.cnt + 4'h1;
                        end
                    end
                end
                ST_RACK: begin
                    if (rise_ev) begin
                        if (!in_bit) begin
                            st_next.state = ST_RLOAD;
                        end else begin
                            st_next.state = ST_IDLE;
                        end
                    end
                end
                default: begin
                    st_next.state = ST_IDLE;
                    st_next.sda_oe_n = 1'b1;
                end
            endcase
        end

        if (!st_reg.commit) begin
            st_next.mem_addr = st_next.addr;
        end
        st_next.busy = st_next.commit | (st_next.busy_cnt != 32'h0);
    end

    // Lines assumed high at power-up
    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg <= '0;
            st_reg.scl_m <= 1'b1;
            st_reg.scl_s <= 1'b1;
            st_reg.scl_d <= 1'b1;
            st_reg.sda_m <= 1'b1;
            st_reg.sda_s <= 1'b1;
            st_reg.sda_d <= 1'b1;
            st_reg.state <= ST_IDLE;
            st_reg.after_ack <= ST_IDLE;
            st_reg.sda_oe_n <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Storage and outputs

    assign mif.wr_en = st_reg.mem_we;
    assign mif.addr = st_reg.mem_addr;
    assign mif.wdata = st_reg.mem_wd;

    eem_mem u_mem (
        .clk(clk),
        .rst(rst),
        .bus(mif.mem)
    );

    assign sda_out = st_reg.sda_out;
    assign sda_oe_n = st_reg.sda_oe_n;
    assign write_busy = st_reg.busy;

endmodule // eem_slave
`default_nettype wire

// ===== bench/eem_bus_master.sv
/*
 Bus master model: drives the bus clock and pulls the data line low.
 Assumes clk at 100 MHz and a pull-up on the data line outside.
*/
`timescale 1ns/100ps
`default_nettype none
module eem_bus_master #(
    parameter int QTR = 50
) (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_pull
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic q(input int n);
        repeat (n) @(posedge clk);
    endtask
    // One clock pulse while reset holds
    task automatic pulse();
        scl <= 1'b0;
        q(2);
        scl <= 1'b1;
        q(2);
    endtask
    // Also serves as repeated start
    task automatic start();
        sda_pull <= 1'b0;
        q(QTR);
        scl <= 1'b1;
        q(QTR);
        sda_pull <= 1'b1;
        q(QTR);
        scl <= 1'b0;
        q(QTR);
    endtask
    task automatic stop();
        sda_pull <= 1'b1;
        q(QTR);
        scl <= 1'b1;
        q(QTR);
        sda_pull <= 1'b0;
        q(2 * QTR);
    endtask
    task automatic put_bit(input logic b);
        sda_pull <= ~b;
        q(QTR);
        scl <= 1'b1;
        q(2 * QTR);
        scl <= 1'b0;
        q(QTR);
    endtask
    task automatic get_bit(output logic b);
        sda_pull <= 1'b0;
        q(QTR);
        scl <= 1'b1;
        q(QTR);
        b = sda;
        q(QTR);
        scl <= 1'b0;
        q(QTR);
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i]);
        end
        get_bit(a);
        ack = ~a;
    endtask
    task automatic rd_byte(input logic last, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            get_bit(d[i]);
        end
        put_bit(last);
    endtask
endmodule // eem_bus_master
`default_nettype wire

// ===== bench/eem_slave_chk.sv
/*
 Concurrent checks on the slave's pins.
 Assumes bus lines are sampled on clk; bound from the bench.
*/
`timescale 1ns/100ps
`default_nettype none
module eem_slave_chk #(
    parameter int WRITE_CYCLES = 50
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl_clk,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic strap_addr_bit0,
    input wire logic strap_addr_bit1,
    input wire logic strap_addr_bit2,
    input wire logic write_busy
);
    logic sda_q_reg;
    logic seen_start_reg;
    int busy_cnt_reg;
    always_ff @(posedge clk) begin
        if (rst) begin
            sda_q_reg <= 1'b1;
            seen_start_reg <= 1'b0;
            busy_cnt_reg <= 0;
        end else begin
            sda_q_reg <= sda_in;
            if (scl_clk && sda_q_reg && !sda_in) begin
                seen_start_reg <= 1'b1;
            end
            busy_cnt_reg <= write_busy ? busy_cnt_reg + 1 : 0;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_bus_idle;
        scl_clk && sda_in;
    endsequence
    sequence s_hold_low;
        (!sda_oe_n) [*8];
    endsequence
    a_reset_values: assert property (
        $fell(rst) |-> sda_oe_n && !write_busy)
        else $error("outputs not idle after reset");
    a_start_first: assert property (
        !seen_start_reg |-> sda_oe_n)
        else $error("data driven before any start");
    a_drive_zero: assert property (
        !sda_oe_n |-> !sda_out)
        else $error("enabled data not low");
    a_change_scl_low: assert property (
        $changed(sda_oe_n) |-> !scl_clk)
        else $error("data changed while clock high");
    a_pull_holds: assert property (
        $fell(sda_oe_n) |-> s_hold_low)
        else $error("pull low too short");
    a_quiet_busy: assert property (
        write_busy && $past(write_busy) |-> sda_oe_n)
        else $error("answered during internal write");
    a_busy_after_stop: assert property (
        $rose(write_busy) |-> s_bus_idle)
        else $error("write began without stop");
    a_busy_span: assert property (
        $fell(write_busy) |-> busy_cnt_reg >= WRITE_CYCLES &&
        busy_cnt_reg <= WRITE_CYCLES + 20)
        else $error("internal write time wrong");
    a_busy_bound: assert property (
        busy_cnt_reg <= WRITE_CYCLES + 20)
        else $error("internal write too long");
endmodule // eem_slave_chk
`default_nettype wire

// ===== bench/tb.sv
/*
 Self-checking bench of the two-wire slave, 4K variant and a 1K variant on the same bus.
 Assumes the master model and the checker are compiled before it.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
    import eem_pkg::*;
    typedef struct packed {
        logic [7:0] slave;
        logic ack;
    } eem_row_t;
    localparam int WCYC = 3000;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic strap_addr_bit0 = 1'b1;
    logic strap_addr_bit1 = 1'b0;
    logic strap_addr_bit2 = 1'b1;
    logic scl;
    logic m_pull;
    logic sda_line;
    logic sda_out;
    logic sda_oe_n;
    logic write_busy;
    logic [2:0] strap_1k = 3'h3;
    logic sda_1k_out;
    logic sda_1k_oe_n;
    logic busy_1k;
    int n_mismatch = 0;
    int n_compared = 0;
    eem_row_t rows [5] = '{'{8'h58, 1'b1}, '{8'h5A, 1'b1},
        '{8'h78, 1'b0}, '{8'h50, 1'b0}, '{8'h5C, 1'b0}};
    logic [7:0] pg [4] = '{8'h3C, 8'hA5, 8'h96, 8'h4B};
    always #5 clk = ~clk;
    // Open drain with pull-up
    assign sda_line = (sda_oe_n | sda_out) & (sda_1k_oe_n | sda_1k_out)
                      & ~m_pull;
    eem_slave #(.VARIANT(EEM_4K), .DEV_TYPE(4'h5), .WRITE_CYCLES(WCYC)) i_dut (
        .clk(clk), .rst(rst), .scl_clk(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .strap_addr_bit0(strap_addr_bit0), .strap_addr_bit1(strap_addr_bit1),
        .strap_addr_bit2(strap_addr_bit2), .write_busy(write_busy));
    // Small variant sharing the bus, other straps
    eem_slave #(.VARIANT(EEM_1K), .DEV_TYPE(4'h5), .WRITE_CYCLES(200))
        i_dut_1k (
        .clk(clk), .rst(rst), .scl_clk(scl), .sda_in(sda_line),
        .sda_out(sda_1k_out), .sda_oe_n(sda_1k_oe_n),
        .strap_addr_bit0(strap_1k[0]), .strap_addr_bit1(strap_1k[1]),
        .strap_addr_bit2(strap_1k[2]), .write_busy(busy_1k));
    eem_bus_master #(.QTR(50)) i_master (
        .clk(clk), .sda(sda_line), .scl(scl), .sda_pull(m_pull));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] b, input logic exp_ack);
        logic a;
        i_master.wr_byte(b, a);
        chk(a, exp_ack);
    endtask
    task automatic set_ptr(input logic [7:0] sl, input logic [7:0] wa);
        i_master.start();
        wr(sl, 1'b1);
        wr(wa, 1'b1);
    endtask
    task automatic rd(input logic [7:0] sl, input logic [7:0] e0,
                      input logic [7:0] e1, input int n);
        logic [7:0] v;
        i_master.start();
        wr(sl, 1'b1);
        for (int i = 0; i < n; i++) begin
            i_master.rd_byte(i == n - 1, v);
            chk(v, i == 0 ? e0 : e1);
        end
        chk(sda_line, 1'b1);
        i_master.stop();
    endtask
    task automatic tally_and_finish();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (90000) @(posedge clk);
        n_mismatch++;
        $display("watchdog expired");
        tally_and_finish();
    end
    initial begin
        repeat (3) @(posedge clk);
        i_master.pulse();
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk(sda_oe_n, 1'b1);
        chk(write_busy, 1'b0);
        chk(sda_1k_oe_n, 1'b1);
        $display("reset test done");
        foreach (rows[i]) begin
            i_master.start();
            wr(rows[i].slave, rows[i].ack);
            i_master.stop();
        end
        $display("address table done");
        set_ptr(8'h5A, 8'h1E);
        foreach (pg[k]) begin
            wr(pg[k], 1'b1);
        end
        i_master.stop();
        chk(write_busy, 1'b1);
        i_master.start();
        wr(8'h5A, 1'b0);
        i_master.stop();
        for (int w = 0; w < 4000 && write_busy !== 1'b0; w++) begin
            @(posedge clk);
        end
        chk(write_busy, 1'b0);
        $display("page write done");
        set_ptr(8'h5A, 8'h10);
        rd(8'h5B, pg[2], 8'h00, 1);
        rd(8'h5B, pg[3], 8'h00, 1);
        set_ptr(8'h5A, 8'h1E);
        rd(8'h5B, pg[0], pg[1], 2);
        $display("read tests done");
        set_ptr(8'h56, 8'hFF);
        wr(8'hC3, 1'b1);
        wr(8'hE1, 1'b1);
        i_master.stop();
        chk(busy_1k, 1'b1);
        for (int w = 0; w < 400 && busy_1k !== 1'b0; w++) begin
            @(posedge clk);
        end
        chk(busy_1k, 1'b0);
        set_ptr(8'h56, 8'h7C);
        rd(8'h57, 8'hE1, ERASED_BYTE, 2);
        $display("small variant done");
        set_ptr(8'h58, 8'h1E);
        wr(8'h77, 1'b1);
        set_ptr(8'h58, 8'h1E);
        rd(8'h59, ERASED_BYTE, 8'h00, 1);
        chk(write_busy, 1'b0);
        $display("aborted write done");
        tally_and_finish();
    end
endmodule // tb
bind eem_slave eem_slave_chk #(.WRITE_CYCLES(WRITE_CYCLES)) i_chk (
    .clk(clk), .rst(rst), .scl_clk(scl_clk), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .strap_addr_bit0(strap_addr_bit0), .strap_addr_bit1(strap_addr_bit1),
    .strap_addr_bit2(strap_addr_bit2), .write_busy(write_busy));
`default_nettype wire
